/* core/pdt_dur_cnt.sv */
/*
 * Saturating duration counter in step units.
 * Assumes run is a same-clock level; clears the cycle after run drops.
 */
`timescale 1ns/1ps
module pdt_dur_cnt
#(
    parameter int W = 25,
    parameter int STEP = 10
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    output logic [W-1:0] cnt_reg
);
    localparam logic [W-1:0] MAX_VAL = {W{1'b1}};
    localparam logic [W-1:0] STEP_VAL = W'(STEP);

    if (STEP < 1 || W < 4)
    begin : g_chk
        $error("pdt_dur_cnt: unusable width or step");
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_reg <= '0;
        else if (!run)
            cnt_reg <= '0;
        else if (cnt_reg > MAX_VAL - STEP_VAL)
            cnt_reg <= MAX_VAL;
        else
            cnt_reg <= cnt_reg + STEP_VAL;
    end
endmodule : pdt_dur_cnt

/* core/pdt_pkg.sv */
/*
 * Constants, codes and register map of the pattern duration trigger.
 * Assumes a 10 MHz APB clock and durations programmed in 10 ns units.
 */
// Summary of operation
// R1 - entry: fire when all used channels match
// R2 - entry: wait for count separate matches
// R3 - exit: fire when match ends, after count
// R4 - longer: fire at end if long enough
// R5 - longer: too short occurrence restarts search
// R6 - duration limited to 20 ns..160 ms, 10 ns
// R7 - shorter: fire at end if short enough
// R8 - shorter: overlong occurrence is abandoned
// R9 - range: fire at end if within bounds
// R10 - range: out of bounds occurrence discarded
// R11 - upper bound at least one step above lower; only checked on upper bound writes, a lower bound write may reach or pass it
// R12 - only first occurrence needs duration test
// R13 - trigger at end of completing occurrence
// R14 - count 1 to 32000, default 1
// R15 - occurrence needs all used channels together
// R16 - mode resets to on-entry
// R17 - element is high, low or ignore
// R18 - all-ignore pattern never matches
// R19 - elements reset to ignore
// R20 - duration counter runs while matching
// R21 - comparator inputs synchronised before use
package pdt_pkg;
    localparam int PDT_NCH = 2;
    localparam int PDT_DUR_W = 25;
    localparam int PDT_CNT_W = 15;
    localparam int PDT_ADDR_W = 8;

    // register byte offsets
    localparam logic [7:0] PDT_OFS_CTRL = 8'h00;
    localparam logic [7:0] PDT_OFS_PATTERN = 8'h04;
    localparam logic [7:0] PDT_OFS_COUNT = 8'h08;
    localparam logic [7:0] PDT_OFS_DUR_LO = 8'h0c;
    localparam logic [7:0] PDT_OFS_DUR_HI = 8'h10;
    localparam logic [7:0] PDT_OFS_ARM = 8'h14;
    localparam logic [7:0] PDT_OFS_STATUS = 8'h18;

    // field positions
    localparam int PDT_CTRL_MODE_LSB = 0;
    localparam int PDT_ARM_BIT = 0;
    localparam int PDT_ST_ARMED_BIT = 0;
    localparam int PDT_ST_FIRED_BIT = 1;
    localparam int PDT_ST_MATCH_BIT = 2;
    localparam int PDT_ST_QUAL_BIT = 3;
    localparam int PDT_ST_OCC_LSB = 16;

    // pattern element codes, two bits per channel
    localparam logic [1:0] PDT_ELEM_IGNORE = 2'h0;
    localparam logic [1:0] PDT_ELEM_LOW = 2'h1;
    localparam logic [1:0] PDT_ELEM_HIGH = 2'h2;

    typedef enum logic [2:0]
    {
        PDT_MODE_ENTRY = 3'h0,
        PDT_MODE_EXIT = 3'h1,
        PDT_MODE_LONGER = 3'h2,
        PDT_MODE_SHORTER = 3'h3,
        PDT_MODE_RANGE = 3'h4
    } pdt_mode_t;

    typedef enum logic [2:0]
    {
        PDT_ST_IDLE = 3'h1,
        PDT_ST_ARMED = 3'h2,
        PDT_ST_FIRED = 3'h4
    } pdt_state_t;

    // timing
    localparam int PDT_CLK_PERIOD_NS = 100;
    localparam int PDT_STEP_NS = 10;
    localparam int PDT_CLK_STEPS = PDT_CLK_PERIOD_NS / PDT_STEP_NS;
    localparam int PDT_DUR_MIN_NS = 20;
    localparam longint PDT_DUR_MAX_NS = 160_000_000;
    localparam logic [31:0] PDT_DUR_MIN_STEPS =
        32'(PDT_DUR_MIN_NS / PDT_STEP_NS);
    localparam logic [31:0] PDT_DUR_MAX_STEPS =
        32'(PDT_DUR_MAX_NS / PDT_STEP_NS);
    localparam logic [31:0] PDT_COUNT_MIN = 32'h0000_0001;
    localparam logic [31:0] PDT_COUNT_MAX = 32'h0000_7d00;

    // reset values
    localparam logic [PDT_CNT_W-1:0] PDT_COUNT_RST = 15'h0001;
    localparam logic [PDT_DUR_W-1:0] PDT_DUR_LO_RST = 25'h000_0002;
    localparam logic [PDT_DUR_W-1:0] PDT_DUR_HI_RST = 25'h000_0003;
endpackage : pdt_pkg

/* core/pdt_sync.sv */
/*
 * Two-stage synchroniser for a bus of independent level inputs.
 * Assumes each bit is a slow level; no word coherence across bits.
 */
`timescale 1ns/1ps
module pdt_sync
#(
    parameter int W = 2
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : pdt_sync

/* core/pdt_trigger.sv */
/*
 * Pattern duration trigger qualifier with its APB register file.
 * Assumes comparator outputs are asynchronous levels and that the
 * APB master follows the standard setup/access protocol.
 */
`timescale 1ns/1ps
module pdt_trigger
    import pdt_pkg::*;
#(
    parameter int NCH = PDT_NCH
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PDT_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NCH-1:0] cmp_hi,
    output logic trig_pulse,
    output logic trig_done
);
    if (NCH < 1 || NCH > 16)
    begin : g_chk
        $error("pdt_trigger: NCH must be 1 to 16");
    end

    // configuration
    pdt_mode_t mode_reg;
    logic [2*NCH-1:0] pattern_reg;
    logic [PDT_CNT_W-1:0] count_reg;
    logic [PDT_DUR_W-1:0] dur_lo_reg;
    logic [PDT_DUR_W-1:0] dur_hi_reg;

    // qualifier state
    pdt_state_t state_reg;
    logic [PDT_CNT_W-1:0] occ_reg;
    logic [PDT_CNT_W-1:0] occ_inc;
    logic qual_reg;
    logic match_reg;
    logic trig_pulse_reg;
    logic [31:0] prdata_reg;

    logic [NCH-1:0] cmp_sync;
    logic [NCH-1:0] ch_ok;
    logic [NCH-1:0] ch_used;
    logic match_now;
    logic rise;
    logic fall;
    logic [PDT_DUR_W-1:0] dur_cnt;
    logic dur_ok;
    logic complete;

    // bus decode
    logic wr_access;
    logic rd_setup;
    logic arm_wr;
    logic addr_ok;
    logic val_ok;
    logic [31:0] rdata_mux;

    pdt_sync #(.W(NCH)) u_sync
    (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(cmp_hi),
        .sync_out(cmp_sync) // R21
    );

    // element decode per channel
    always_comb
    begin
        for (int i = 0; i < NCH; i++)
        begin
            ch_used[i] = (pattern_reg[2*i +: 2] == PDT_ELEM_HIGH) ||
                (pattern_reg[2*i +: 2] == PDT_ELEM_LOW); // R17
            ch_ok[i] = !ch_used[i] ||
                ((pattern_reg[2*i +: 2] == PDT_ELEM_HIGH) ?
                cmp_sync[i] : !cmp_sync[i]); // R17
        end
    end

    // an all-ignore pattern is not a wildcard
    assign match_now = (|ch_used) && (&ch_ok); // R15 R18

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            match_reg <= 1'b0;
        else
            match_reg <= match_now;
    end

    assign rise = match_now && !match_reg;
    assign fall = !match_now && match_reg;

    // clock is coarser than the 10 ns unit: resolution is one period
    pdt_dur_cnt #(.W(PDT_DUR_W), .STEP(PDT_CLK_STEPS)) u_dur
    (
        .pclk(pclk),
        .presetn(presetn),
        .run(match_now), // R20
        .cnt_reg(dur_cnt)
    );

    // at a fall, dur_cnt still holds the length of the ended occurrence
    always_comb
    begin
        unique case (mode_reg)
            PDT_MODE_LONGER:
                dur_ok = dur_cnt >= dur_lo_reg; // R4 R5
            PDT_MODE_SHORTER:
                dur_ok = dur_cnt < dur_lo_reg; // R7 R8
            PDT_MODE_RANGE:
                dur_ok = (dur_cnt > dur_lo_reg) &&
                    (dur_cnt < dur_hi_reg); // R9 R10
            default:
                dur_ok = 1'b0;
        endcase
    end

    assign occ_inc = occ_reg + PDT_CNT_W'(1);
    assign complete = occ_inc == count_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= PDT_ST_IDLE;
            occ_reg <= '0;
            qual_reg <= 1'b0;
            trig_pulse_reg <= 1'b0;
        end
        else
        begin
            trig_pulse_reg <= 1'b0;
            if (arm_wr)
            begin
                // a new arm restarts the search from scratch
                state_reg <= PDT_ST_ARMED;
                occ_reg <= '0;
                qual_reg <= 1'b0;
            end
            else
            begin
                unique case (state_reg)
                    PDT_ST_IDLE, PDT_ST_FIRED:
                    begin
                    end
                    PDT_ST_ARMED:
                    begin
                        unique case (mode_reg)
                            PDT_MODE_ENTRY:
                            begin
                                if (rise && complete) // R1 R2
                                begin
                                    state_reg <= PDT_ST_FIRED;
                                    trig_pulse_reg <= 1'b1;
                                    occ_reg <= occ_inc;
                                end
                                else if (rise)
                                    occ_reg <= occ_inc; // R2
                            end
                            PDT_MODE_EXIT:
                            begin
                                if (rise && occ_reg != count_reg)
                                    occ_reg <= occ_inc; // R3
                                if (fall && occ_reg == count_reg) // R3
                                begin
                                    state_reg <= PDT_ST_FIRED;
                                    trig_pulse_reg <= 1'b1;
                                end
                            end
                            default:
                            begin
                                if (fall && !qual_reg && dur_ok)
                                begin
                                    qual_reg <= 1'b1; // R12
                                    occ_reg <= PDT_CNT_W'(1);
                                    if (count_reg == PDT_CNT_W'(1))
                                    begin
                                        state_reg <= PDT_ST_FIRED; // R13
                                        trig_pulse_reg <= 1'b1;
                                    end
                                end
                                else if (fall && qual_reg)
                                begin
                                    occ_reg <= occ_inc; // R12
                                    if (complete)
                                    begin
                                        state_reg <= PDT_ST_FIRED; // R13
                                        trig_pulse_reg <= 1'b1;
                                    end
                                end
                            end
                        endcase
                    end
                    default:
                        state_reg <= PDT_ST_IDLE;
                endcase
            end
        end
    end

    assign trig_pulse = trig_pulse_reg;
    assign trig_done = state_reg == PDT_ST_FIRED;

    // APB slave: zero wait states, read data captured in setup
    assign wr_access = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign pready = 1'b1;

    always_comb
    begin
        unique case (paddr)
            PDT_OFS_CTRL, PDT_OFS_PATTERN, PDT_OFS_COUNT,
            PDT_OFS_DUR_LO, PDT_OFS_DUR_HI, PDT_OFS_ARM,
            PDT_OFS_STATUS:
                addr_ok = 1'b1;
            default:
                addr_ok = 1'b0;
        endcase
    end

    // out-of-range settings are refused whole and flagged with pslverr
    always_comb
    begin
        unique case (paddr)
            PDT_OFS_CTRL:
                val_ok = pwdata[PDT_CTRL_MODE_LSB +: 3] <=
                    PDT_MODE_RANGE;
            PDT_OFS_COUNT:
                val_ok = (pwdata >= PDT_COUNT_MIN) &&
                    (pwdata <= PDT_COUNT_MAX); // R14
            PDT_OFS_DUR_LO:
                val_ok = (pwdata >= PDT_DUR_MIN_STEPS) &&
                    (pwdata <= PDT_DUR_MAX_STEPS); // R6 R11
            PDT_OFS_DUR_HI:
                val_ok = (pwdata > 32'(dur_lo_reg)) &&
                    (pwdata <= PDT_DUR_MAX_STEPS + 32'h1); // R11
            default:
                val_ok = 1'b1;
        endcase
    end

    assign pslverr = psel && penable && (!addr_ok || (pwrite && !val_ok));
    assign arm_wr = wr_access && paddr == PDT_OFS_ARM && pwdata[PDT_ARM_BIT];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_reg <= PDT_MODE_ENTRY; // R16
            pattern_reg <= '0; // R19
            count_reg <= PDT_COUNT_RST; // R14
            dur_lo_reg <= PDT_DUR_LO_RST;
            dur_hi_reg <= PDT_DUR_HI_RST;
        end
        else if (wr_access && val_ok)
        begin
            unique case (paddr)
                PDT_OFS_CTRL:
                    mode_reg <= pdt_mode_t'(pwdata[PDT_CTRL_MODE_LSB +: 3]);
                PDT_OFS_PATTERN:
                    pattern_reg <= pwdata[2*NCH-1:0];
                PDT_OFS_COUNT:
                    count_reg <= pwdata[PDT_CNT_W-1:0];
                PDT_OFS_DUR_LO:
                    dur_lo_reg <= pwdata[PDT_DUR_W-1:0];
                PDT_OFS_DUR_HI:
                    dur_hi_reg <= pwdata[PDT_DUR_W-1:0];
                default:
                begin
                end
            endcase
        end
    end

    always_comb
    begin
        rdata_mux = '0;
        unique case (paddr)
            PDT_OFS_CTRL:
                rdata_mux[PDT_CTRL_MODE_LSB +: 3] = mode_reg;
            PDT_OFS_PATTERN:
                rdata_mux[2*NCH-1:0] = pattern_reg;
            PDT_OFS_COUNT:
                rdata_mux[PDT_CNT_W-1:0] = count_reg;
            PDT_OFS_DUR_LO:
                rdata_mux[PDT_DUR_W-1:0] = dur_lo_reg;
            PDT_OFS_DUR_HI:
                rdata_mux[PDT_DUR_W-1:0] = dur_hi_reg;
            PDT_OFS_STATUS:
            begin
                rdata_mux[PDT_ST_ARMED_BIT] = state_reg == PDT_ST_ARMED;
                rdata_mux[PDT_ST_FIRED_BIT] = state_reg == PDT_ST_FIRED;
                rdata_mux[PDT_ST_MATCH_BIT] = match_reg;
                rdata_mux[PDT_ST_QUAL_BIT] = qual_reg;
                rdata_mux[PDT_ST_OCC_LSB +: PDT_CNT_W] = occ_reg;
            end
            default:
            begin
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= '0;
        else if (rd_setup)
            prdata_reg <= rdata_mux;
    end

    assign prdata = prdata_reg;
endmodule : pdt_trigger

/* testbench/pdt_cmp_model.sv */
/* comparator outputs of the probed signals.
   assumes drive is called just after a pclk edge. */
`timescale 1ns/1ps
module pdt_cmp_model
(
    input wire logic pclk,
    output logic [1:0] cmp_hi
);
    initial cmp_hi = 2'h0;
    // level v for w cycles, then both low for g cycles
    task automatic drive(input logic [1:0] v, input int w, input int g);
        cmp_hi <= v;
        repeat (w) @(posedge pclk);
        cmp_hi <= 2'h0;
        repeat (g) @(posedge pclk);
    endtask : drive
endmodule : pdt_cmp_model

/* testbench/pdt_trigger_chk.sv */
/* assertions on the trigger outputs and bus refusals.
   sees only pdt_trigger ports; bound at the foot. */
`timescale 1ns/1ps
module pdt_trigger_chk
    import pdt_pkg::*;
#(
    parameter int NCH = PDT_NCH
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PDT_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NCH-1:0] cmp_hi,
    input wire logic trig_pulse,
    input wire logic trig_done
);
    logic pat_zero_reg;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence wr_s(logic [7:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence
    sequence arm_s;
        wr_s(PDT_OFS_ARM) ##0 pwdata[0];
    endsequence
    // shadow of the pattern: true while no channel is used
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            pat_zero_reg <= 1'b1;
        else if (psel && penable && pwrite && paddr == PDT_OFS_PATTERN)
            pat_zero_reg <= pwdata[1:0] inside {2'h0, 2'h3} &&
                pwdata[3:2] inside {2'h0, 2'h3};
    pulse_single_a: assert property (trig_pulse |=> !trig_pulse)
        else $error("trigger pulse too long");
    done_with_a: assert property (trig_pulse |-> trig_done)
        else $error("done missing at trigger");
    fire_once_a: assert property ($past(trig_done) |-> !trig_pulse)
        else $error("second trigger in one arm");
    arm_clear_a: assert property (arm_s |=> !trig_done)
        else $error("arm did not clear done");
    done_hold_a: assert property ($fell(trig_done) |->
        $past(psel && penable && pwrite && paddr == PDT_OFS_ARM))
        else $error("done dropped without arm");
    sync_cause_a: assert property (trig_pulse |->
        $past(cmp_hi, 3) != $past(cmp_hi, 4))
        else $error("trigger without input change");
    all_ignore_a: assert property (pat_zero_reg &&
        $past(pat_zero_reg) && $past(pat_zero_reg, 2) |-> !trig_pulse)
        else $error("trigger with no channel used");
    count_refuse_a: assert property (wr_s(PDT_OFS_COUNT) ##0
        (pwdata == 32'h0 || pwdata > PDT_COUNT_MAX) |-> pslverr)
        else $error("illegal count accepted");
    dur_refuse_a: assert property (wr_s(PDT_OFS_DUR_LO) ##0
        (pwdata < PDT_DUR_MIN_STEPS || pwdata > PDT_DUR_MAX_STEPS)
        |-> pslverr)
        else $error("illegal duration accepted");
endmodule : pdt_trigger_chk

bind pdt_trigger pdt_trigger_chk #(.NCH(NCH)) u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_hi(cmp_hi), .trig_pulse(trig_pulse),
    .trig_done(trig_done));

/* testbench/pdt_trigger_tb_top.sv */
/* self-checking bench: apb master, comparator model, queued checks.
   assumes 3-cycle trigger latency; apb waits are taken as they come. */
`timescale 1ns/1ps
module pdt_trigger_tb_top
    import pdt_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic trig_pulse, trig_done;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0] cmp_hi;
    logic [32:0] bus_q[$];
    int trig_q[$];
    int cyc, errors, total_checks, m_cfg, pat_cfg, cnt_cfg, lo_cfg, hi_cfg;
    pdt_trigger dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_hi(cmp_hi), .trig_pulse(trig_pulse),
        .trig_done(trig_done));
    pdt_cmp_model cmp (.pclk(pclk), .cmp_hi(cmp_hi));
    initial pclk = 1'b0;
    always #50 pclk = ~pclk;
    task automatic close_out();
        // a note never matched means a missing result
        if (bus_q.size() > 0 || trig_q.size() > 0)
            errors++;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out
    task automatic cmp_bus(input logic [32:0] g, input logic [32:0] e);
        total_checks++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp_bus
    task automatic cmp_trig(input int g, input int e);
        cmp_bus(33'(g), 33'(e));
    endtask : cmp_trig
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors++;
            close_out();
        end
        if (presetn && psel && penable && pready !== 1'b0)
            cmp_bus({pslverr, pwrite ? 32'h0 : prdata}, bus_q.pop_front());
        // an unknown pulse is compared too, so it cannot slip past
        if (presetn && trig_pulse !== 1'b0)
            cmp_trig(cyc, trig_q.size() > 0 ? trig_q.pop_front() : -1);
    end
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [32:0] e);
        bus_q.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no fixed wait: only the bench timeout ends a stalled access
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic e);
        apb(1'b1, a, d, {e, 32'h0});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask : rd
    task automatic setup(input int m, input int p, input int c,
        input int lo, input int hi);
        m_cfg = m;
        pat_cfg = p;
        cnt_cfg = c;
        lo_cfg = lo;
        hi_cfg = hi;
        wr(PDT_OFS_CTRL, m, 1'b0);
        wr(PDT_OFS_PATTERN, p, 1'b0);
        wr(PDT_OFS_COUNT, c, 1'b0);
        // upper bound first, so it never sits below the lower one
        wr(PDT_OFS_DUR_HI, hi, 1'b0);
        wr(PDT_OFS_DUR_LO, lo, 1'b0);
        wr(PDT_OFS_ARM, 1, 1'b0);
    endtask : setup
    // pulses of ws cycles; reference count decides the firing edge
    task automatic train(input logic [1:0] v, input logic rm,
        input int ws[6]);
        int occ, d, r;
        logic ok;
        occ = 0;
        foreach (ws[i])
        begin
            d = ws[i] * 10;
            ok = m_cfg < 2 || (m_cfg == 2 && d >= lo_cfg) ||
                (m_cfg == 3 && d < lo_cfg) ||
                (m_cfg == 4 && d > lo_cfg && d < hi_cfg);
            ok = pat_cfg != 0 && (ok || occ > 0);
            if (ok)
                occ++;
            r = cyc;
            if (ok && occ == cnt_cfg)
                trig_q.push_back(m_cfg == 0 ? r + 4 : r + ws[i] + 4);
            cmp.drive(v | {rm & 1'($urandom), 1'b0}, ws[i], 4);
        end
        repeat (4) @(posedge pclk);
    endtask : train
    initial
    begin
        void'($urandom(32'h7e7a3e91));
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(PDT_OFS_CTRL, 32'h0);
        rd(PDT_OFS_PATTERN, 32'h0);
        rd(PDT_OFS_COUNT, 32'h1);
        rd(PDT_OFS_DUR_LO, 32'h2);
        rd(PDT_OFS_DUR_HI, 32'h3);
        apb(1'b0, 8'h1c, 32'h0, {1'b1, 32'h0});
        wr(PDT_OFS_COUNT, 32'h0, 1'b1);
        wr(PDT_OFS_COUNT, 32'd32001, 1'b1);
        wr(PDT_OFS_COUNT, 32'd32000, 1'b0);
        rd(PDT_OFS_COUNT, 32'd32000);
        wr(PDT_OFS_DUR_LO, 32'h1, 1'b1);
        wr(PDT_OFS_DUR_LO, 32'd16000001, 1'b1);
        wr(PDT_OFS_DUR_HI, 32'd16000002, 1'b1);
        // all-ignore written while armed: a wildcard match would fire
        setup(0, 2, 1, 40, 70);
        wr(PDT_OFS_PATTERN, 32'hf, 1'b0);
        pat_cfg = 0;
        train(2'b01, 1'b1, '{3, 3, 3, 3, 3, 3});
        rd(PDT_OFS_STATUS, 32'h0000_0001);
        setup(0, 6, 1, 40, 70);
        cmp.drive(2'b11, 3, 4);
        train(2'b01, 1'b0, '{3, 3, 3, 3, 3, 3});
        rd(PDT_OFS_STATUS, 32'h0001_0002);
        setup(0, 2, 3, 40, 70);
        train(2'b01, 1'b1, '{3, 2, 4, 3, 2, 3});
        setup(1, 2, 2, 40, 70);
        train(2'b01, 1'b1, '{2, 5, 3, 2, 4, 2});
        setup(2, 2, 3, 40, 70);
        train(2'b01, 1'b1, '{2, 6, 1, 2, 1, 8});
        setup(3, 2, 3, 40, 70);
        train(2'b01, 1'b1, '{6, 2, 5, 1, 7, 1});
        setup(4, 2, 3, 30, 70);
        train(2'b01, 1'b1, '{9, 1, 5, 9, 1, 2});
        rd(PDT_OFS_STATUS, 32'h0003_000a);
        close_out();
    end
endmodule : pdt_trigger_tb_top
